//--- pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,            // Clock
    input wire logic resetn_in,         // Async reset, active low
    input wire logic [W-1:0] d_in,      // Asynchronous pin level
    output logic [W-1:0] q_out          // Filtered level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++)
        begin
            if (s2_r[i] == s3_r[i])
                q_nxt[i] = s3_r[i];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end
        else
        begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;
endmodule // pin_sync
`default_nettype wire

//--- prom_mode_pin_access.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Chip reset pin held low selects the memory-programming mode directly.
// - In that mode port pins form a byte-wide EPROM-like memory interface.
// - Select and gate low with address given: stored byte driven on data.
// - Data lines float whenever select or output gate is high.
// - Program state entered only while the programming level is present.
// - In program state, select going low starts writing the presented byte.
// - Whole of port zero serves as the bidirectional 8-bit data bus.
module prom_mode_pin_access
    import prom_pkg::*;
(
    input wire logic clk_in,                          // 200 MHz clock
    input wire logic resetn_in,                       // Async reset, low
    input wire logic chip_reset_low_in,               // Chip reset pin
    input wire logic chip_select_low_in,              // Chip select, low
    input wire logic output_gate_low_in,              // Output gate, low
    input wire logic program_supply_in,               // Programming level
    input wire logic [prom_pkg::ADDR_W-1:0] address_lines_in, // Address
    input wire logic [prom_pkg::DATA_W-1:0] port_zero_in,     // Data in
    output logic [prom_pkg::DATA_W-1:0] port_zero_out,        // Data out
    output logic [prom_pkg::DATA_W-1:0] port_zero_oe_n_out,   // Low drives
    output logic prom_mode_out,                       // Programming mode
    output logic write_busy_out                       // Write in progress
);
    import prom_pkg::*;

    localparam int NSYNC = 4 + ADDR_W + DATA_W;

    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] syn;
    logic mode;
    logic cs_n;
    logic oe_n;
    logic vpp;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;

    assign raw = {~chip_reset_low_in, chip_select_low_in, output_gate_low_in,
                  program_supply_in, address_lines_in, port_zero_in};

    pin_sync #(
        .W(NSYNC)
    ) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in(raw),
        .q_out(syn)
    );

    assign mode = syn[NSYNC-1];
    assign cs_n = syn[NSYNC-2];
    assign oe_n = syn[NSYNC-3];
    assign vpp = syn[NSYNC-4];
    assign addr = syn[ADDR_W+DATA_W-1:DATA_W];
    assign din = syn[DATA_W-1:0];

    // Program memory; erased state reads all ones. The initialiser
    // keeps the write process the only one that assigns the array.
    logic [DATA_W-1:0] mem [MEM_DEPTH] = '{default: ERASED_BYTE};

    prog_state_e state_r;
    prog_state_e state_nxt;
    logic [PROG_CNT_W-1:0] cnt_r;
    logic [PROG_CNT_W-1:0] cnt_nxt;
    logic [ADDR_W-1:0] waddr_r;
    logic [ADDR_W-1:0] waddr_nxt;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] wdata_nxt;
    logic do_write;
    logic [DATA_W-1:0] dout_r;
    logic [DATA_W-1:0] dout_nxt;
    logic drive_r;
    logic drive_nxt;

    function automatic logic read_enabled(input logic m, input logic c,
                                          input logic o);
        read_enabled = m && !c && !o;
    endfunction

    // Write sequencer: select low in program state latches one byte
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        do_write = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (mode && vpp && oe_n && !cs_n)
                begin
                    state_nxt = ST_WRITE;
                    cnt_nxt = PROG_CNT_INIT;
                    waddr_nxt = addr;
                    wdata_nxt = din;
                end
            end
            ST_WRITE:
            begin
                // Dropping supply or mode aborts; cell keeps old contents
                if (!mode || !vpp)
                    state_nxt = ST_IDLE;
                else if (cnt_r == PROG_CNT_W'(1))
                begin
                    do_write = 1'b1;
                    state_nxt = ST_DONE;
                end
                else
                    cnt_nxt = cnt_r - PROG_CNT_W'(1);
            end
            ST_DONE:
            begin
                // Wait for select to rise so a long pulse writes once
                if (cs_n || !mode || !vpp)
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            waddr_r <= '0;
            wdata_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Memory array has no reset; it models the erased cells
    always_ff @(posedge clk_in)
    begin
        if (do_write)
            mem[waddr_r] <= wdata_r;
    end

    // Read and verify share one path; verify just has the supply raised
    always_comb
    begin
        drive_nxt = read_enabled(mode, cs_n, oe_n);
        dout_nxt = drive_nxt ? mem[addr] : dout_r;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dout_r <= '0;
            drive_r <= 1'b0;
        end
        else
        begin
            dout_r <= dout_nxt;
            drive_r <= drive_nxt;
        end
    end

    assign port_zero_out = dout_r;
    assign port_zero_oe_n_out = {DATA_W{~drive_r}};
    assign prom_mode_out = mode;
    assign write_busy_out = (state_r == ST_WRITE);

    a_float_when_off: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (cs_n || oe_n || !mode) |=> (port_zero_oe_n_out == '1))
        else $error("data bus driven while select or gate high");

    a_read_drives: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (mode && !cs_n && !oe_n) |=> (port_zero_oe_n_out == '0 &&
            port_zero_out == $past(mem[addr])))
        else $error("read did not drive stored byte");

    a_verify_drives: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (mode && vpp && !cs_n && !oe_n) |=> !port_zero_oe_n_out[0])
        else $error("verify did not drive data");

    a_write_needs_vpp: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (state_r == ST_IDLE && !vpp) |=> state_r == ST_IDLE)
        else $error("program state entered without supply");

    a_write_start: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (state_r == ST_IDLE && mode && vpp && oe_n && !cs_n)
        |=> (state_r == ST_WRITE && waddr_r == $past(addr)))
        else $error("select low did not start write");

    a_write_length: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        $rose(write_busy_out) && mode && vpp |-> ##19 (do_write ||
            !write_busy_out))
        else $error("write pulse length wrong");

    a_no_mode_idle: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !mode |=> (state_r == ST_IDLE && port_zero_oe_n_out == '1))
        else $error("activity outside programming mode");

    a_write_commits: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        do_write |=> mem[$past(waddr_r)] == $past(wdata_r))
        else $error("byte not stored");

    a_one_write_pulse: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (state_r == ST_DONE && !cs_n && mode && vpp) |=> state_r == ST_DONE)
        else $error("long select pulse started a second write");

    a_busy_holds: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        (state_r == ST_WRITE && mode && vpp && cnt_r != PROG_CNT_W'(1))
        |=> write_busy_out)
        else $error("write timing ended early");
endmodule // prom_mode_pin_access
`default_nettype wire

//--- prom_pkg.sv
package prom_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 32768;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Program pulse length in ns and derived cycles at 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PROG_TIME_NS = 100;
    localparam int PROG_CYCLES = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PROG_CNT_W = 8;
    localparam logic [7:0] PROG_CNT_INIT = 8'(PROG_CYCLES);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_DONE = 2'b10
    } prog_state_e;
endpackage

//--- prom_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module prom_programmer
    import prom_pkg::*;
(
    input wire logic clk_in, // Clock
    input wire logic [prom_pkg::DATA_W-1:0] dev_data_in, // Device data
    input wire logic [prom_pkg::DATA_W-1:0] dev_oe_n_in, // Device drive, low
    input wire logic busy_in, // Write timing
    output logic ce_n_out, // Select, low
    output logic oe_n_out, // Gate, low
    output logic vpp_out, // Programming level
    output logic [prom_pkg::ADDR_W-1:0] addr_out, // Address
    output logic [prom_pkg::DATA_W-1:0] bus_out // Resolved data bus
);
    logic drv = 1'b0;
    logic [DATA_W-1:0] wdat = 8'h00;
    // No pull-up here, so a released bus shows the inverse of the last byte
    assign bus_out = drv ? wdat : (dev_oe_n_in[0] ? ~wdat : dev_data_in);
    initial
    begin
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        vpp_out = 1'b0;
        addr_out = '0;
    end
    task automatic pins(input logic c, input logic o, input logic v);
        ce_n_out = c;
        oe_n_out = o;
        vpp_out = v;
        repeat (6) @(posedge clk_in);
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output bit ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        addr_out = a;
        ce_n_out = 1'b0;
        oe_n_out = 1'b0;
        for (n = 0; n < 12 && dev_oe_n_in !== 8'h00; n++)
            @(posedge clk_in) #1;
        ok = (dev_oe_n_in === 8'h00);
        d = bus_out;
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        for (n = 0; n < 12 && dev_oe_n_in !== 8'hFF; n++)
            @(posedge clk_in) #1;
        if (dev_oe_n_in !== 8'hFF) ok = 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                      output bit ok);
        int n;
        oe_n_out = 1'b1;
        addr_out = a;
        wdat = v;
        drv = 1'b1;
        @(posedge clk_in) #1;
        ce_n_out = 1'b0;
        for (n = 0; n < 12 && busy_in !== 1'b1; n++)
            @(posedge clk_in) #1;
        ok = (busy_in === 1'b1);
        for (n = 0; n < 40 && busy_in !== 1'b0; n++)
            @(posedge clk_in) #1;
        if (busy_in !== 1'b0) ok = 1'b0;
        ce_n_out = 1'b1;
        drv = 1'b0;
        repeat (6) @(posedge clk_in);
        #1;
    endtask
endmodule // prom_programmer
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import prom_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic chip_reset_low_in = 1'b1;
    logic ce_n, oe_n, vpp, mode, busy;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] pz_in, pz_out, pz_oe_n, d;
    bit ok;
    int failures = 0;
    int comparisons = 0;
    always #2.5 clk_in = ~clk_in;
    prom_programmer prom_programmer_i (.clk_in(clk_in), .dev_data_in(pz_out),
        .dev_oe_n_in(pz_oe_n), .busy_in(busy), .ce_n_out(ce_n),
        .oe_n_out(oe_n), .vpp_out(vpp), .addr_out(addr), .bus_out(pz_in));
    prom_mode_pin_access prom_mode_pin_access_i (.clk_in(clk_in),
        .resetn_in(resetn_in), .chip_reset_low_in(chip_reset_low_in),
        .chip_select_low_in(ce_n), .output_gate_low_in(oe_n),
        .program_supply_in(vpp), .address_lines_in(addr),
        .port_zero_in(pz_in), .port_zero_out(pz_out),
        .port_zero_oe_n_out(pz_oe_n), .prom_mode_out(mode),
        .write_busy_out(busy));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_mode;
        prom_programmer_i.rd(15'h7FFF, d, ok);
        chk({7'h00, ok}, 8'h00);
        chk({7'h00, mode}, 8'h00);
        chip_reset_low_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
        chk({7'h00, mode}, 8'h01);
        $display("done t_mode");
    endtask
    task automatic t_float;
        prom_programmer_i.pins(1'b0, 1'b1, 1'b0);
        chk(pz_oe_n, 8'hFF);
        prom_programmer_i.pins(1'b1, 1'b0, 1'b0);
        chk(pz_oe_n, 8'hFF);
        prom_programmer_i.pins(1'b1, 1'b1, 1'b0);
        $display("done t_float");
    endtask
    task automatic t_no_vpp;
        prom_programmer_i.wr(15'h6001, 8'h00, ok);
        chk({7'h00, ok}, 8'h00);
        prom_programmer_i.rd(15'h6001, d, ok);
        chk(d, ERASED_BYTE);
        chk({7'h00, ok}, 8'h01);
        $display("done t_no_vpp");
    endtask
    task automatic t_prog;
        prom_programmer_i.pins(1'b1, 1'b1, 1'b1);
        prom_programmer_i.wr(15'h6000, 8'hA5, ok);
        chk({7'h00, ok}, 8'h01);
        prom_programmer_i.wr(15'h7FFF, 8'h5A, ok);
        chk({7'h00, ok}, 8'h01);
        prom_programmer_i.wr(15'h3FFF, ERASED_BYTE, ok);
        chk({7'h00, ok}, 8'h01);
        prom_programmer_i.rd(15'h7FFF, d, ok);
        chk(d, 8'h5A);
        prom_programmer_i.rd(15'h6000, d, ok);
        chk(d, 8'hA5);
        prom_programmer_i.pins(1'b1, 1'b1, 1'b0);
        prom_programmer_i.rd(15'h6000, d, ok);
        chk(d, 8'hA5);
        prom_programmer_i.rd(15'h3FFF, d, ok);
        chk(d, ERASED_BYTE);
        $display("done t_prog");
    endtask
    initial
    begin
        repeat (5) @(posedge clk_in);
        #1;
        chk(pz_oe_n, 8'hFF);
        chk({6'h00, mode, busy}, 8'h00);
        resetn_in = 1'b1;
        t_mode();
        t_float();
        t_no_vpp();
        t_prog();
        wrap_up();
    end
    // About 220 cycles of traffic; the limit leaves ample margin
    initial
    begin
        #20000;
        failures++;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
